/* File: test/eiad_contacts.sv */
`timescale 1ns/1ns
`default_nettype none
module eiad_contacts (
    input wire logic clk_sys,
    input wire logic [3:0] lvl_req,
    output logic [3:0] event_in
);
    initial event_in = 4'h0;
    // four contacts
    // contacts settle only just after a clock edge, held steady between requests
    always @(posedge clk_sys) begin
        event_in <= lvl_req;
    end
endmodule : eiad_contacts
`default_nettype wire

/* File: test/eiad_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "eiad_consts.svh"
module eiad_top_tb_top;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, act_fire, rd, tbl [32];
    logic pready, pslverr, act_valid, er, mode12 = 1'b0;
    logic [2:0] act_event;
    logic [127:0] act_aspect;
    logic [3:0] lvl_req = 4'h0, event_in;
    logic [2:0] q_ev [$];
    logic [31:0] q_fire [$];
    logic [3:0] q_asp [$];
    int q_cyc [$];
    int err_total = 0, n_compared = 0, cyc = 0;
    always #10 clk_sys = ~clk_sys;
    eiad_contacts eiad_contacts_inst (.clk_sys(clk_sys), .lvl_req(lvl_req), .event_in(event_in));
    eiad_top eiad_top_inst (.clk_sys(clk_sys), .rstn(rstn), .event_in(event_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .act_valid(act_valid), .act_event(act_event),
        .act_fire(act_fire), .act_aspect(act_aspect));
    always @(posedge clk_sys) begin
        cyc++;
        // a hung handshake ends the run here
        if (cyc == 6000) begin
            err_total++;
            conclude();
        end
    end
    always @(negedge clk_sys) begin
        if (act_valid === 1'b1) begin
            q_ev.push_back(act_event);
            q_fire.push_back(act_fire);
            q_asp.push_back(act_aspect[15:12]);
            q_cyc.push_back(cyc);
        end
    end
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // setup after an edge, then hold until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // read data and error are taken at the very edge that sees pready high
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
        chk({31'h0, er}, 32'h00000000);
    endtask : rchk
    function automatic logic [31:0] exp_fire(input logic [2:0] e);
        logic [31:0] f;
        logic [3:0] ent;
        for (int p = 0; p < 32; p++) begin
            ent = tbl[p][4*e+:4];
            f[p] = (ent != `EIAD_ENTRY_NONE) &&
                (ent < (mode12 ? `EIAD_ASPECTS_LARGE : `EIAD_ASPECTS_SMALL));
        end
        return f;
    endfunction : exp_fire
    // move the contacts and check the dispatches that follow, in index order
    task automatic burst(input logic [3:0] lvl, input logic [7:0] evs, input string name);
        int last;
        lvl_req <= lvl;
        repeat (20) @(posedge clk_sys);
        last = -1;
        for (int e = 0; e < 8; e++) begin
            if (evs[e]) begin
                chk(32'(q_ev.size() > 0), 32'h1);
                if (q_ev.size() > 0) begin
                    chk(32'(q_ev.pop_front()), 32'(e));
                    chk(q_fire.pop_front(), exp_fire(3'(e)));
                    chk(32'(q_asp.pop_front()), 32'(e));
                    if (last >= 0) chk(32'(q_cyc[0] - last), 32'h1);
                    last = q_cyc.pop_front();
                end
            end
        end
        chk(32'(q_ev.size()), 32'h0);
        $display("test %s done", name);
    endtask : burst
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rchk(`EIAD_OFF_INIT_MASK, 32'h000000ff);
        rchk(`EIAD_OFF_ACT_MASK, 32'h000000ff);
        rchk(`EIAD_OFF_CTRL, 32'h00000000);
        rchk(12'h100, `EIAD_MEM_RST);
        apb(1'b1, 12'h040, 32'h12345678);
        chk({31'h0, er}, 32'h00000001);
        chk(rd, 32'h00000000);
        $display("test reset done");
        apb(1'b1, `EIAD_OFF_ALL_DATA, 32'h3f1ff0ff);
        for (int p = 0; p < 32; p++) tbl[p] = 32'h3f1ff0ff;
        apb(1'b1, `EIAD_OFF_PIN_SEL, 32'h00000003);
        apb(1'b1, `EIAD_OFF_PIN_DATA, 32'h76543210);
        tbl[3] = 32'h76543210;
        rchk(`EIAD_OFF_PIN_DATA, 32'h76543210);
        rchk(12'h10c, 32'h76543210);
        rchk(12'h110, 32'h3f1ff0ff);
        rchk(12'h17c, 32'h3f1ff0ff);
        apb(1'b1, `EIAD_OFF_INIT_MASK, 32'h0000000f);
        rchk(`EIAD_OFF_INIT_MASK, 32'h0000000f);
        rchk(`EIAD_OFF_ACT_MASK, 32'h000000ff);
        rchk(12'h10c, 32'h76543210);
        $display("test tables done");
        // four sets, all inputs at once
        burst(4'hf, 8'h0f, "rise_all");
        burst(4'h0, 8'hf0, "fall_all");
        apb(1'b1, `EIAD_OFF_CTRL, 32'h00000001);
        mode12 = 1'b1;
        apb(1'b1, `EIAD_OFF_ACT_MASK, 32'h00000050);
        rchk(`EIAD_OFF_INIT_MASK, 32'h0000000f);
        rchk(`EIAD_OFF_ACT_MASK, 32'h00000050);
        burst(4'hf, 8'h00, "rise_masked");
        burst(4'h0, 8'h50, "fall_twelve");
        apb(1'b1, `EIAD_OFF_ACT_MASK, 32'h00000004);
        burst(4'h4, 8'h04, "single");
        rchk(`EIAD_OFF_STATUS, 32'h00000004);
        apb(1'b1, `EIAD_OFF_ACT_MASK, 32'h00000000);
        burst(4'h8, 8'h00, "swap_masked");
        apb(1'b1, `EIAD_OFF_ACT_MASK, 32'h00000081);
        burst(4'h1, 8'h81, "both_ends");
        // set five ignored with four sets
        apb(1'b1, `EIAD_OFF_CTRL, 32'h00000000);
        mode12 = 1'b0;
        apb(1'b1, `EIAD_OFF_PIN_SEL, 32'h00000001);
        apb(1'b1, `EIAD_OFF_PIN_DATA, 32'h3f15f0ff);
        tbl[1] = 32'h3f15f0ff;
        apb(1'b1, `EIAD_OFF_ACT_MASK, 32'h00000010);
        burst(4'h0, 8'h10, "small_limit");
        conclude();
    end
endmodule : eiad_top_tb_top
`default_nettype wire

/* File: verilog/eiad_consts.svh */
// What this block does
// (RULE_01) four external event inputs, 0 to 3, are each watched on their own for level changes.
// (RULE_02) each input gives an activation event on turning active and a deactivation event on turning inactive, eight events in all.
// (RULE_03) every one of the 32 output pins stores one entry per event for all eight events, naming the action set 0 to 11 it fires.
// (RULE_04) an entry holding minus one (4'hf) makes that event do nothing on that pin.
// (RULE_05) an eight-bit enable mask lets an event dispatch its per-pin actions only while its bit is set; the code checks the bit only on arrival.
// (RULE_06) an event whose enable bit is clear is dropped entirely and fires nothing.
// (RULE_07) at start-up the active mask is loaded from the stored initial mask.
// (RULE_08) a run-time event-input instruction rewrites the active mask and leaves the stored initial mask alone.
// (RULE_09) a fired action set runs that pin's instruction list; a pin has 4 or 12 action sets by a setting.
// (RULE_10) the host reads or writes the entries of one selected pin, or of all pins, and gets exactly those; an all-pins read gets the selected pin only.
// (RULE_11) the stored initial mask is read and written as its own transfer, apart from the pin tables.
// (RULE_12) each input is synchronised and edge-detected so each transition gives one single-cycle pulse.
// (RULE_13) events arriving together are dispatched lowest index first, one per cycle, none lost.
`ifndef EIAD_CONSTS_SVH
`define EIAD_CONSTS_SVH

`define EIAD_OFF_CTRL 12'h000
`define EIAD_OFF_INIT_MASK 12'h004
`define EIAD_OFF_ACT_MASK 12'h008
`define EIAD_OFF_STATUS 12'h00c
`define EIAD_OFF_PIN_SEL 12'h010
`define EIAD_OFF_PIN_DATA 12'h014
`define EIAD_OFF_ALL_DATA 12'h018
`define EIAD_TABLE_BASE_HI 5'h02
`define EIAD_CTRL_MODE12_BIT 0
`define EIAD_ENTRY_NONE 4'hf
`define EIAD_ASPECTS_SMALL 4'h4
`define EIAD_ASPECTS_LARGE 4'hc
`define EIAD_INIT_MASK_RST 8'hff
`define EIAD_MEM_RST 32'hffffffff
`define EIAD_PINS 32
`define EIAD_EVENTS 8

`endif

/* File: verilog/eiad_edge.sv */
`timescale 1ns/1ns
`default_nettype none
module eiad_edge #(
    parameter int N = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [N-1:0] din,
    output logic [N-1:0] lvl,
    output logic [N-1:0] rise,
    output logic [N-1:0] fall
);
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
        logic [N-1:0] prev;
    } eiad_edge_t;

    eiad_edge_t s_r;
    eiad_edge_t s_nxt;

    // meta feeds only sync; the edge logic looks at sync and prev
    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = din;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lvl = s_r.sync;
    // (RULE_12) one pulse each edge
    assign rise = s_r.sync & ~s_r.prev;
    assign fall = ~s_r.sync & s_r.prev;
endmodule : eiad_edge
`default_nettype wire

/* File: verilog/eiad_pkg.sv */
`default_nettype none
package eiad_pkg;

typedef logic [3:0] eiad_entry_t;
typedef logic [31:0] eiad_word_t;

typedef struct packed {
    logic [31:0][31:0] mem;
    logic mode12;
    logic [7:0] init_mask;
    logic [7:0] act_mask;
    logic started;
    logic [4:0] pin_sel;
    logic [7:0] pend;
    logic [31:0] fire;
    logic [31:0][3:0] aspect;
    logic [2:0] fire_ev;
    logic fire_valid;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
} eiad_state_t;

endpackage : eiad_pkg
`default_nettype wire

/* File: verilog/eiad_top.sv */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "eiad_consts.svh"
module eiad_top #(
    parameter int N_IN = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [N_IN-1:0] event_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic act_valid,
    output logic [2:0] act_event,
    output logic [31:0] act_fire,
    output logic [127:0] act_aspect
);
    eiad_pkg::eiad_state_t s_r;
    eiad_pkg::eiad_state_t s_nxt;
    logic rst_meta_r;
    logic rst_n_s;
    logic [N_IN-1:0] lvl;
    logic [N_IN-1:0] ev_rise;
    logic [N_IN-1:0] ev_fall;
    logic [7:0] ev_new;
    logic setup;
    logic wr;
    logic [2:0] serve_idx;
    logic serve_any;

    // reset is asserted at once but released only through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s <= rst_meta_r;
        end
    end

    // (RULE_01) independent input watch
    eiad_edge #(
        .N(N_IN)
    ) eiad_edge_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n_s),
        .din(event_in),
        .lvl(lvl),
        .rise(ev_rise),
        .fall(ev_fall)
    );

    // (RULE_02) on events low, off high
    assign ev_new = {4'(ev_fall), 4'(ev_rise)};

    function automatic eiad_pkg::eiad_entry_t get_entry(
        input eiad_pkg::eiad_word_t w,
        input logic [2:0] ev
    );
        get_entry = w[{ev, 2'b00} +: 4];
    endfunction : get_entry

    // entries past the pin's set count, and the do-nothing code, fire nothing
    function automatic logic is_action(input eiad_pkg::eiad_entry_t e, input logic mode12);
        logic [3:0] lim;
        lim = mode12 ? `EIAD_ASPECTS_LARGE : `EIAD_ASPECTS_SMALL;
        is_action = (e != `EIAD_ENTRY_NONE) && (e < lim);
    endfunction : is_action

    function automatic logic [2:0] lowest(input logic [7:0] v);
        lowest = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                lowest = 3'(i);
            end
        end
    endfunction : lowest

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && s_r.pready;
    // (RULE_13) lowest pending first
    assign serve_idx = lowest(s_r.pend);
    assign serve_any = |s_r.pend;

    always_comb begin
        logic hit;
        logic [31:0] rd;
        eiad_pkg::eiad_entry_t e;
        hit = 1'b0;
        rd = 32'h0;
        e = 4'h0;
        s_nxt = s_r;

        // answer in the cycle after setup, so every access has no wait state
        s_nxt.pready = setup;
        s_nxt.pslverr = 1'b0;
        if (setup) begin
            hit = 1'b1;
            if (paddr[11:7] == `EIAD_TABLE_BASE_HI && paddr[1:0] == 2'b00) begin
                // (RULE_10) all pins readable
                rd = s_r.mem[paddr[6:2]];
            end else begin
                unique case (paddr)
                    `EIAD_OFF_CTRL: rd = {31'h0, s_r.mode12};
                    // (RULE_11) initial mask alone
                    `EIAD_OFF_INIT_MASK: rd = {24'h0, s_r.init_mask};
                    `EIAD_OFF_ACT_MASK: rd = {24'h0, s_r.act_mask};
                    `EIAD_OFF_STATUS: rd = {20'h0, s_r.pend, 4'(lvl)};
                    `EIAD_OFF_PIN_SEL: rd = {27'h0, s_r.pin_sel};
                    // (RULE_10) selected pin read
                    `EIAD_OFF_PIN_DATA: rd = s_r.mem[s_r.pin_sel];
                    `EIAD_OFF_ALL_DATA: rd = s_r.mem[s_r.pin_sel];
                    default: hit = 1'b0;
                endcase
            end
            s_nxt.prdata = rd;
            s_nxt.pslverr = !hit;
        end

        if (wr && !s_r.pslverr) begin
            if (paddr[11:7] == `EIAD_TABLE_BASE_HI) begin
                s_nxt.mem[paddr[6:2]] = pwdata;
            end else begin
                unique case (paddr)
                    `EIAD_OFF_CTRL: s_nxt.mode12 = pwdata[`EIAD_CTRL_MODE12_BIT];
                    // (RULE_11) initial mask write
                    `EIAD_OFF_INIT_MASK: s_nxt.init_mask = pwdata[7:0];
                    // (RULE_08) run-time mask instruction
                    `EIAD_OFF_ACT_MASK: s_nxt.act_mask = pwdata[7:0];
                    `EIAD_OFF_PIN_SEL: s_nxt.pin_sel = pwdata[4:0];
                    // (RULE_10) one pin only
                    `EIAD_OFF_PIN_DATA: s_nxt.mem[s_r.pin_sel] = pwdata;
                    `EIAD_OFF_ALL_DATA: begin
                        // (RULE_10) every pin at once
                        for (int p = 0; p < `EIAD_PINS; p++) begin
                            s_nxt.mem[p] = pwdata;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // (RULE_07) load active from stored
        if (!s_r.started) begin
            s_nxt.started = 1'b1;
            s_nxt.act_mask = s_r.init_mask;
        end

        // dispatch: one event a cycle, the served bit is cleared below
        s_nxt.fire_valid = serve_any;
        s_nxt.fire_ev = serve_idx;
        for (int p = 0; p < `EIAD_PINS; p++) begin
            e = get_entry(s_r.mem[p], serve_idx);
            // (RULE_03) per-pin per-event entry
            s_nxt.aspect[p] = e;
            // (RULE_04) (RULE_09) skip do-nothing
            s_nxt.fire[p] = serve_any && is_action(e, s_r.mode12);
        end

        // (RULE_05) (RULE_06) masked events dropped
        // new arrivals win over the clear of the bit just served
        s_nxt.pend = (s_r.pend & ~(serve_any ? (8'h01 << serve_idx) : 8'h00))
                   | (ev_new & s_r.act_mask);
    end

    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            s_r <= '0;
            s_r.mem <= {`EIAD_PINS{`EIAD_MEM_RST}};
            s_r.init_mask <= `EIAD_INIT_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign act_valid = s_r.fire_valid;
    assign act_event = s_r.fire_ev;
    assign act_fire = s_r.fire;
    assign act_aspect = s_r.aspect;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n_s);

    property p_on_event;
        $rose(lvl[0]) && s_r.act_mask[0] |=> s_r.pend[0];
    endproperty
    a_on_event: assert property (p_on_event) else $error("on event lost"); // RULE_02

    property p_off_event;
        $fell(lvl[3]) |-> ev_new[7] && !ev_new[3];
    endproperty
    a_off_event: assert property (p_off_event) else $error("off event wrong"); // RULE_02

    property p_single_pulse;
        ev_rise[1] |=> !ev_rise[1];
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("pulse too long"); // RULE_12

    property p_masked_drop;
        ev_new[2] && !s_r.act_mask[2] && !s_r.pend[2] |=> !s_r.pend[2];
    endproperty
    a_masked_drop: assert property (p_masked_drop) else $error("masked event kept"); // RULE_06

    property p_order_kept;
        s_r.pend[0] && s_r.pend[7] |=> act_valid && act_event == 3'h0 && s_r.pend[7];
    endproperty
    a_order_kept: assert property (p_order_kept) else $error("order broken"); // RULE_13

    property p_fire_cause;
        act_valid |-> $past(serve_any) && act_event == $past(serve_idx);
    endproperty
    a_fire_cause: assert property (p_fire_cause) else $error("fire without event"); // RULE_05

    property p_none_code;
        serve_any && get_entry(s_r.mem[0], serve_idx) == `EIAD_ENTRY_NONE |=> !act_fire[0];
    endproperty
    a_none_code: assert property (p_none_code) else $error("do-nothing fired"); // RULE_04

    property p_small_mode;
        serve_any && !s_r.mode12 && get_entry(s_r.mem[1], serve_idx) == 4'h5 |=> !act_fire[1];
    endproperty
    a_small_mode: assert property (p_small_mode) else $error("set beyond four fired"); // RULE_09

    property p_fire_entry;
        serve_any && get_entry(s_r.mem[2], serve_idx) == 4'h3 |=> act_fire[2] && act_aspect[11:8] == 4'h3;
    endproperty
    a_fire_entry: assert property (p_fire_entry) else $error("entry not fired"); // RULE_03

    property p_start_load;
        $rose(s_r.started) |-> s_r.act_mask == $past(s_r.init_mask);
    endproperty
    a_start_load: assert property (p_start_load) else $error("mask not loaded"); // RULE_07

    property p_instr_keeps_init;
        wr && paddr == `EIAD_OFF_ACT_MASK && !s_r.pslverr
            |=> s_r.init_mask == $past(s_r.init_mask) && s_r.act_mask == $past(pwdata[7:0]);
    endproperty
    a_instr_keeps_init: assert property (p_instr_keeps_init) else $error("mask write wrong"); // RULE_08

    property p_pin_write;
        wr && paddr == `EIAD_OFF_PIN_DATA && !s_r.pslverr
            |=> s_r.mem[$past(s_r.pin_sel)] == $past(pwdata);
    endproperty
    a_pin_write: assert property (p_pin_write) else $error("pin entry not stored"); // RULE_10

    property p_init_read;
        setup && paddr == `EIAD_OFF_INIT_MASK |=> prdata == {24'h0, $past(s_r.init_mask)} && pready;
    endproperty
    a_init_read: assert property (p_init_read) else $error("initial mask read wrong"); // RULE_11
endmodule : eiad_top
`default_nettype wire
